// ===== core/lin_stepper_cmd_decoder.sv
// Purpose: Device-side decoder for four application commands
// Assumes: Frame ends are signalled after the last master byte
// Notes: Parameter memory is eight bytes, written from the user side
// Notes on behaviour
// - Master sends preparing frame, code 0x02
// - Short preparing frame layout with dynamic identifier
// - Long preparing frame with fixed bytes, fillers
// - Master follows with the fixed reading header
// - Answer eight memory bytes, ascending address
// - Byte two carries live address pins
// - Quick status answers two defined bytes
// - Quick status clears the latched fault flags
// - Code 0x04 moves to safe position
// - Address bit seven low means broadcast
// - Safe position 0x400 disables the move
// - Lost bus or init end starts move
// - Code 0x05 is emergency stop, broadcastable
// - Coil fault stops and switches bridges off
// - Fault during motion raises lost step
// - Dynamic identifiers carry parity in top bits
module lin_stepper_cmd_decoder (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Sync reset, active low
  lin_frame_if.slave bus, // Frame carrier
  input wire logic [6:0] node_addr_in, // Own node address
  input wire logic [4:0] prep_id_in, // Preparing frame identifier
  input wire logic [4:0] status_id_in, // Quick status identifier
  input wire logic [4:0] write_id_in, // Two-byte writing identifier
  input wire logic [2:0] addr_pins_in, // Hardwired address pins
  input wire logic ext_switch_in, // External switch state
  input wire logic [1:0] temp_level_in, // Temperature level
  input wire logic [10:0] safe_pos_in, // Stored safe position
  input wire logic [8:0] fault_evt_in, // Flag set events
  input wire logic [1:0] coil_fault_in, // Coil electrical fault
  input wire logic motor_moving_in, // Motor not at rest
  input wire logic comm_lost_in, // Bus communication lost pulse
  input wire logic init_done_in, // Init run finished pulse
  input wire logic otp_we_in, // Parameter memory write
  input wire logic [2:0] otp_addr_in, // Parameter memory address
  input wire logic [7:0] otp_wdata_in, // Parameter memory data
  output logic goto_safe_out, // Start safe move, pulse
  output logic estop_out, // Emergency stop, pulse
  output logic bridge_off_out, // Bridge drivers off
  output logic [8:0] flags_out, // Sticky fault flags
  output logic param_armed_out // Reading frame will be answered
);
  typedef enum logic [1:0] {D_IDLE, D_RX, D_TX} dstate_t;
  typedef enum logic [1:0] {RX_SHORT_PREP, RX_SHORT_WRITE, RX_LONG} rxkind_t;
  typedef struct packed {
    dstate_t state;
    rxkind_t rx_kind;
    logic [3:0] cnt;
    logic [2:0][7:0] keep;
    logic fill_ok;
    logic tx_status;
    logic armed;
    logic [7:0][7:0] otp;
    logic [8:0] flags;
    logic goto_safe;
    logic estop;
    logic bridge_off;
    logic sdat_stb;
    logic [7:0] sdat;
  } dev_state_t;
  localparam dev_state_t DEV_RST = '{state: D_IDLE, rx_kind: RX_LONG,
    flags: lin_cmd_pkg::FLAGS_RST, default: '0};

  dev_state_t s_reg;
  dev_state_t s_next;
  logic [8:0] flag_set;
  logic [8:0] flag_clr;
  logic safe_req;
  logic dyn;

  function automatic logic [7:0] resp_byte(input logic is_status,
                                           input logic [3:0] idx,
                                           input dev_state_t s);
    logic [7:0] b;
    b = s.otp[idx[2:0]];
    if (is_status) begin
      if (idx == 4'h0) begin
        b = {ext_switch_in, node_addr_in};
      end else begin
        b = {s.flags[lin_cmd_pkg::FLG_SUPPLY_RESET],
             s.flags[lin_cmd_pkg::FLG_LOST_STEP],
             s.flags[lin_cmd_pkg::FLG_ELECTRICAL_DEFECT],
             s.flags[lin_cmd_pkg::FLG_UNDERVOLTAGE],
             s.flags[lin_cmd_pkg::FLG_THERMAL_SHUTDOWN],
             s.flags[lin_cmd_pkg::FLG_THERMAL_WARNING],
             temp_level_in};
      end
    end else if (idx[2:0] == lin_cmd_pkg::OTP_ADDR_BYTE) begin
      // Pins are not stored, so they are read live
      b = {s.otp[idx[2:0]][7], addr_pins_in, s.otp[idx[2:0]][3:0]};
    end
    return b;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a,
                                   input logic bcast_allowed);
    return (bcast_allowed && !a[lin_cmd_pkg::TOP_BIT]) ||
           (a[lin_cmd_pkg::TOP_BIT] && a[6:0] == node_addr_in);
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.goto_safe = 1'b0;
    s_next.estop = 1'b0;
    s_next.sdat_stb = 1'b0;
    flag_set = fault_evt_in;
    flag_clr = 9'h000;
    safe_req = comm_lost_in || init_done_in;
    dyn = !bus.hdr_ident[lin_cmd_pkg::IDENT_DYN_BIT];
    if (otp_we_in) begin
      s_next.otp[otp_addr_in] = otp_wdata_in;
    end
    case (s_reg.state)
      D_IDLE: begin
        s_next.cnt = 4'h0;
        s_next.fill_ok = 1'b1;
        if (bus.hdr_stb) begin
          if (bus.hdr_ident == lin_cmd_pkg::IDENT_READ && s_reg.armed) begin
            s_next.state = D_TX;
            s_next.tx_status = 1'b0;
            s_next.armed = 1'b0;
            s_next.sdat = resp_byte(1'b0, 4'h0, s_reg);
            s_next.sdat_stb = 1'b1;
            s_next.cnt = 4'h1;
          end else if (dyn && bus.hdr_ident[4:0] == status_id_in) begin
            s_next.state = D_TX;
            s_next.tx_status = 1'b1;
            s_next.sdat = resp_byte(1'b1, 4'h0, s_reg);
            s_next.sdat_stb = 1'b1;
            s_next.cnt = 4'h1;
          end else if (bus.hdr_ident == lin_cmd_pkg::IDENT_LONG) begin
            s_next.state = D_RX;
            s_next.rx_kind = RX_LONG;
          end else if (dyn && bus.hdr_ident[4:0] == prep_id_in) begin
            s_next.state = D_RX;
            s_next.rx_kind = RX_SHORT_PREP;
          end else if (dyn && bus.hdr_ident[4:0] == write_id_in) begin
            s_next.state = D_RX;
            s_next.rx_kind = RX_SHORT_WRITE;
          end
        end
      end
      D_RX: begin
        if (bus.mdat_stb) begin
          if (s_reg.cnt < lin_cmd_pkg::KEEP_BYTES) begin
            s_next.keep[s_reg.cnt[1:0]] = bus.mdat;
          end else if (bus.mdat != lin_cmd_pkg::FILLER_BYTE) begin
            s_next.fill_ok = 1'b0;
          end
          if (s_reg.cnt != 4'hf) begin
            s_next.cnt = s_reg.cnt + 4'h1;
          end
        end
        if (bus.frm_end) begin
          s_next.state = D_IDLE;
          case (s_reg.rx_kind)
            RX_LONG: begin
              if (s_reg.cnt == lin_cmd_pkg::LONG_BYTES && s_reg.fill_ok &&
                  s_reg.keep[0] == lin_cmd_pkg::APP_CMD_BYTE &&
                  s_reg.keep[1] == {1'b1, lin_cmd_pkg::CMD_READ_PARAM} &&
                  addr_ok(s_reg.keep[2], 1'b0)) begin
                s_next.armed = 1'b1;
              end
            end
            RX_SHORT_PREP: begin
              if (s_reg.cnt == lin_cmd_pkg::SHORT_BYTES &&
                  s_reg.keep[0] == {1'b1, lin_cmd_pkg::CMD_READ_PARAM} &&
                  addr_ok(s_reg.keep[1], 1'b0)) begin
                s_next.armed = 1'b1;
              end
            end
            RX_SHORT_WRITE: begin
              if (s_reg.cnt == lin_cmd_pkg::SHORT_BYTES &&
                  s_reg.keep[0][lin_cmd_pkg::TOP_BIT] &&
                  addr_ok(s_reg.keep[1], 1'b1)) begin
                if (s_reg.keep[0][6:0] == lin_cmd_pkg::CMD_GOTO_SAFE) begin
                  safe_req = 1'b1;
                end
                if (s_reg.keep[0][6:0] == lin_cmd_pkg::CMD_ESTOP) begin
                  s_next.estop = 1'b1;
                end
              end
            end
            default: s_next.state = D_IDLE;
          endcase
        end
      end
      D_TX: begin
        if (s_reg.cnt == (s_reg.tx_status ? lin_cmd_pkg::STATUS_BYTES :
                          lin_cmd_pkg::PARAM_BYTES)) begin
          s_next.state = D_IDLE;
          if (s_reg.tx_status) begin
            flag_clr = lin_cmd_pkg::FLAGS_ALL;
          end
        end else begin
          s_next.sdat = resp_byte(s_reg.tx_status, s_reg.cnt, s_reg);
          s_next.sdat_stb = 1'b1;
          s_next.cnt = s_reg.cnt + 4'h1;
        end
      end
      default: s_next.state = D_IDLE;
    endcase
    if (safe_req && safe_pos_in != lin_cmd_pkg::SAFE_POS_DISABLED) begin
      s_next.goto_safe = 1'b1;
    end
    // Bridges stay off until software has seen the defect
    if (flag_clr[lin_cmd_pkg::FLG_ELECTRICAL_DEFECT]) begin
      s_next.bridge_off = 1'b0;
    end
    if (|coil_fault_in) begin
      s_next.estop = 1'b1;
      s_next.bridge_off = 1'b1;
      flag_set[lin_cmd_pkg::FLG_ELECTRICAL_DEFECT] = 1'b1;
      if (motor_moving_in) begin
        flag_set[lin_cmd_pkg::FLG_LOST_STEP] = 1'b1;
      end
    end
    // A new event in the clearing cycle survives
    s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= DEV_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.sdat_stb = s_reg.sdat_stb;
  assign bus.sdat = s_reg.sdat;
  assign goto_safe_out = s_reg.goto_safe;
  assign estop_out = s_reg.estop;
  assign bridge_off_out = s_reg.bridge_off;
  assign flags_out = s_reg.flags;
  assign param_armed_out = s_reg.armed;
endmodule // lin_stepper_cmd_decoder

// ===== core/lin_cmd_pkg.sv
// Purpose: Shared constants for the stepper command link and its master
// Assumes: Byte-level frames; bit timing handled elsewhere
// Notes: Offsets, codes, field positions and counts for the RTL live here; checks and bench use literals
package lin_cmd_pkg;
  // Command codes, low seven bits of the command byte
  localparam logic [6:0] CMD_READ_PARAM = 7'h02;
  localparam logic [6:0] CMD_GOTO_SAFE = 7'h04;
  localparam logic [6:0] CMD_ESTOP = 7'h05;
  // Fixed identifiers and constant bytes
  localparam logic [7:0] IDENT_LONG = 8'h3c;
  localparam logic [7:0] IDENT_READ = 8'h7d;
  localparam logic [7:0] APP_CMD_BYTE = 8'h80;
  localparam logic [7:0] FILLER_BYTE = 8'hff;
  localparam int IDENT_DYN_BIT = 5;
  localparam int TOP_BIT = 7;
  localparam logic [10:0] SAFE_POS_DISABLED = 11'h400;
  // Byte counts after the identifier
  localparam logic [3:0] PARAM_BYTES = 4'h8;
  localparam logic [3:0] STATUS_BYTES = 4'h2;
  localparam logic [3:0] SHORT_BYTES = 4'h2;
  localparam logic [3:0] LONG_BYTES = 4'h8;
  localparam logic [3:0] KEEP_BYTES = 4'h3;
  localparam logic [2:0] OTP_ADDR_BYTE = 3'h2;
  // Sticky flag positions
  localparam int FLG_THERMAL_WARNING = 0;
  localparam int FLG_THERMAL_SHUTDOWN = 1;
  localparam int FLG_UNDERVOLTAGE = 2;
  localparam int FLG_ELECTRICAL_DEFECT = 3;
  localparam int FLG_LOST_STEP = 4;
  localparam int FLG_CHARGE_PUMP = 5;
  localparam int FLG_COIL_A_OVC = 6;
  localparam int FLG_COIL_B_OVC = 7;
  localparam int FLG_SUPPLY_RESET = 8;
  localparam int NUM_FLAGS = 9;
  localparam logic [8:0] FLAGS_RST = 9'h100;
  localparam logic [8:0] FLAGS_ALL = 9'h1ff;
  // Master register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IDS = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_EVT = 8'h0c;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_DATA_LO = 8'h14;
  localparam logic [7:0] REG_DATA_HI = 8'h18;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_LONG_BIT = 3;
  localparam int CTRL_ADDR_LSB = 4;
  localparam int CTRL_BCAST_BIT = 11;
  localparam int IDS_PREP_LSB = 0;
  localparam int IDS_STATUS_LSB = 5;
  localparam int IDS_WRITE_LSB = 10;
  localparam int EVT_DONE = 0;
  localparam int EVT_TIMEOUT = 1;
  localparam logic [4:0] RESP_TIMEOUT = 5'h10;
  typedef enum logic [2:0] {
    OP_NONE, OP_READ_PARAM, OP_QUICK_STATUS, OP_GOTO_SAFE, OP_ESTOP
  } op_t;
endpackage

// ===== core/lin_frame_if.sv
// Purpose: Byte-level frame carrier between bus master and device
// Assumes: One clock shared by both ends
// Notes: Master publishes header, data and frame end; slave answers bytes
interface lin_frame_if;
  logic hdr_stb;
  logic [7:0] hdr_ident;
  logic mdat_stb;
  logic [7:0] mdat;
  logic frm_end;
  logic sdat_stb;
  logic [7:0] sdat;
  modport master (
    output hdr_stb, hdr_ident, mdat_stb, mdat, frm_end,
    input sdat_stb, sdat
  );
  modport slave (
    input hdr_stb, hdr_ident, mdat_stb, mdat, frm_end,
    output sdat_stb, sdat
  );
endinterface

// ===== core/lin_pid_parity.sv
// Purpose: Protected identifier from a six-bit frame identifier
// Assumes: Pure combinational use
// Notes: Bits 7 and 6 carry the two parity bits
module lin_pid_parity (
  input wire logic [5:0] id_in, // Plain identifier
  output logic [7:0] pid_out // Identifier with parity on top
);
  always_comb begin
    pid_out = {~(id_in[1] ^ id_in[3] ^ id_in[4] ^ id_in[5]),
               id_in[0] ^ id_in[1] ^ id_in[2] ^ id_in[4], id_in};
  end
endmodule // lin_pid_parity

// ===== core/lin_master_ctrl.sv
// Purpose: Bus master end issuing the four commands from registers
// Assumes: Device answers a read header within the response timeout
// Notes: Reads clear the event register; one level interrupt output
module lin_master_ctrl (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Sync reset, active low
  lin_frame_if.master bus, // Frame carrier
  input wire logic [7:0] reg_addr_in, // Register byte address
  input wire logic [31:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [31:0] reg_rdata_out, // Read data, cycle after strobe
  output logic irq_out, // Unmasked event pending
  output logic busy_out // Command in progress
);
  typedef enum logic [2:0] {H_IDLE, H_HDR, H_DATA, H_RESP, H_END} hstate_t;
  typedef struct packed {
    hstate_t state;
    lin_cmd_pkg::op_t op;
    logic long_form;
    logic [6:0] addr;
    logic bcast_n;
    logic [14:0] ids;
    logic second;
    logic [3:0] cnt;
    logic [3:0] len;
    logic [4:0] tmo;
    logic [7:0][7:0] data;
    logic [1:0] evt;
    logic [1:0] mask;
    logic [31:0] rdata;
    logic hdr_stb;
    logic [7:0] hdr_ident;
    logic mdat_stb;
    logic [7:0] mdat;
    logic frm_end;
    logic irq;
  } host_state_t;
  localparam host_state_t HOST_RST = '{state: H_IDLE,
    op: lin_cmd_pkg::OP_NONE, default: '0};

  host_state_t s_reg;
  host_state_t s_next;
  logic [4:0] sel_id;
  logic [7:0] pid;
  logic [1:0] evt_set;
  logic is_read;

  lin_pid_parity u_pid (
    .id_in({1'b0, sel_id}),
    .pid_out(pid)
  );

  function automatic logic [7:0] mbyte(input host_state_t s);
    logic [7:0] b;
    b = lin_cmd_pkg::FILLER_BYTE;
    if (s.op == lin_cmd_pkg::OP_READ_PARAM) begin
      if (s.long_form) begin
        case (s.cnt)
          4'h0: b = lin_cmd_pkg::APP_CMD_BYTE;
          4'h1: b = {1'b1, lin_cmd_pkg::CMD_READ_PARAM};
          4'h2: b = {1'b1, s.addr};
          default: b = lin_cmd_pkg::FILLER_BYTE;
        endcase
      end else begin
        b = (s.cnt == 4'h0) ? {1'b1, lin_cmd_pkg::CMD_READ_PARAM} :
            {1'b1, s.addr};
      end
    end else if (s.cnt == 4'h0) begin
      b = {1'b1, (s.op == lin_cmd_pkg::OP_GOTO_SAFE) ?
           lin_cmd_pkg::CMD_GOTO_SAFE : lin_cmd_pkg::CMD_ESTOP};
    end else begin
      b = {s.bcast_n, s.addr};
    end
    return b;
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.hdr_stb = 1'b0;
    s_next.mdat_stb = 1'b0;
    s_next.frm_end = 1'b0;
    s_next.rdata = 32'h0000_0000;
    evt_set = 2'b00;
    is_read = (s_reg.op == lin_cmd_pkg::OP_QUICK_STATUS) || s_reg.second;
    case (s_reg.op)
      lin_cmd_pkg::OP_READ_PARAM:
        sel_id = s_reg.ids[lin_cmd_pkg::IDS_PREP_LSB +: 5];
      lin_cmd_pkg::OP_QUICK_STATUS:
        sel_id = s_reg.ids[lin_cmd_pkg::IDS_STATUS_LSB +: 5];
      default: sel_id = s_reg.ids[lin_cmd_pkg::IDS_WRITE_LSB +: 5];
    endcase
    if (reg_wr_in) begin
      if (reg_addr_in == lin_cmd_pkg::REG_IDS) begin
        s_next.ids = reg_wdata_in[14:0];
      end else if (reg_addr_in == lin_cmd_pkg::REG_MASK) begin
        s_next.mask = reg_wdata_in[1:0];
      end else if (reg_addr_in == lin_cmd_pkg::REG_CTRL &&
                   s_reg.state == H_IDLE) begin
        s_next.op = lin_cmd_pkg::op_t'(reg_wdata_in[lin_cmd_pkg::CTRL_OP_LSB +: 3]);
        s_next.long_form = reg_wdata_in[lin_cmd_pkg::CTRL_LONG_BIT];
        s_next.addr = reg_wdata_in[lin_cmd_pkg::CTRL_ADDR_LSB +: 7];
        s_next.bcast_n = reg_wdata_in[lin_cmd_pkg::CTRL_BCAST_BIT];
        s_next.second = 1'b0;
        if (s_next.op != lin_cmd_pkg::OP_NONE &&
            reg_wdata_in[2:0] <= 3'(lin_cmd_pkg::OP_ESTOP)) begin
          s_next.state = H_HDR;
        end
      end
    end
    case (s_reg.state)
      H_IDLE: s_next.cnt = 4'h0;
      H_HDR: begin
        s_next.hdr_stb = 1'b1;
        s_next.cnt = 4'h0;
        s_next.tmo = 5'h00;
        if (s_reg.second) begin
          s_next.hdr_ident = lin_cmd_pkg::IDENT_READ;
        end else if (s_reg.op == lin_cmd_pkg::OP_READ_PARAM && s_reg.long_form) begin
          s_next.hdr_ident = lin_cmd_pkg::IDENT_LONG;
        end else begin
          s_next.hdr_ident = pid;
        end
        if (is_read) begin
          s_next.state = H_RESP;
          s_next.len = s_reg.second ? lin_cmd_pkg::PARAM_BYTES :
                       lin_cmd_pkg::STATUS_BYTES;
        end else begin
          s_next.state = H_DATA;
          s_next.len = (s_reg.op == lin_cmd_pkg::OP_READ_PARAM &&
                        s_reg.long_form) ? lin_cmd_pkg::LONG_BYTES :
                       lin_cmd_pkg::SHORT_BYTES;
        end
      end
      H_DATA: begin
        s_next.mdat_stb = 1'b1;
        s_next.mdat = mbyte(s_reg);
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == s_reg.len - 4'h1) begin
          s_next.state = H_END;
        end
      end
      H_RESP: begin
        s_next.tmo = s_reg.tmo + 5'h01;
        if (bus.sdat_stb) begin
          s_next.data[s_reg.cnt[2:0]] = bus.sdat;
          s_next.cnt = s_reg.cnt + 4'h1;
          s_next.tmo = 5'h00;
          if (s_reg.cnt == s_reg.len - 4'h1) begin
            s_next.state = H_END;
          end
        end else if (s_reg.tmo == lin_cmd_pkg::RESP_TIMEOUT) begin
          // Silent slave must not hang the master
          evt_set[lin_cmd_pkg::EVT_TIMEOUT] = 1'b1;
          s_next.state = H_END;
        end
      end
      H_END: begin
        s_next.frm_end = 1'b1;
        if (s_reg.op == lin_cmd_pkg::OP_READ_PARAM && !s_reg.second) begin
          s_next.second = 1'b1;
          s_next.state = H_HDR;
        end else begin
          evt_set[lin_cmd_pkg::EVT_DONE] = 1'b1;
          s_next.state = H_IDLE;
        end
      end
      default: s_next.state = H_IDLE;
    endcase
    if (reg_rd_in) begin
      case (reg_addr_in)
        lin_cmd_pkg::REG_CTRL: s_next.rdata = {20'h0_0000, s_reg.bcast_n,
          s_reg.addr, s_reg.long_form, s_reg.op};
        lin_cmd_pkg::REG_IDS: s_next.rdata = {17'h0_0000, s_reg.ids};
        lin_cmd_pkg::REG_STAT:
          s_next.rdata = {31'h0000_0000, s_reg.state != H_IDLE};
        lin_cmd_pkg::REG_EVT: s_next.rdata = {30'h0000_0000, s_reg.evt};
        lin_cmd_pkg::REG_MASK: s_next.rdata = {30'h0000_0000, s_reg.mask};
        lin_cmd_pkg::REG_DATA_LO: s_next.rdata = s_reg.data[3:0];
        lin_cmd_pkg::REG_DATA_HI: s_next.rdata = s_reg.data[7:4];
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    // Set wins over the read clear
    s_next.evt = ((reg_rd_in && reg_addr_in == lin_cmd_pkg::REG_EVT) ?
                  2'b00 : s_reg.evt) | evt_set;
    s_next.irq = |(s_next.evt & s_next.mask);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= HOST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.hdr_stb = s_reg.hdr_stb;
  assign bus.hdr_ident = s_reg.hdr_ident;
  assign bus.mdat_stb = s_reg.mdat_stb;
  assign bus.mdat = s_reg.mdat;
  assign bus.frm_end = s_reg.frm_end;
  assign reg_rdata_out = s_reg.rdata;
  assign irq_out = s_reg.irq;
  assign busy_out = s_reg.state != H_IDLE;
endmodule // lin_master_ctrl

// ===== sim/lin_frame_sva.sv
// Purpose: Frame carrier checks between master and device
// Assumes: One clock for both ends
// Notes: Sees only the carrier signals
module lin_frame_sva (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic hdr_stb, // Header
  input wire logic [7:0] hdr_ident, // Identifier
  input wire logic mdat_stb, // Master byte
  input wire logic [7:0] mdat, // Master data
  input wire logic frm_end, // Frame over
  input wire logic sdat_stb // Slave byte
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic dyn = hdr_stb && !hdr_ident[5];
  wire logic rdh = hdr_stb && hdr_ident == 8'h7d;
  property p_ans; $rose(sdat_stb) |-> $past(hdr_stb); endproperty
  a_ans: assert property (p_ans) else $error("Stray answer");
  property p_plen; rdh ##1 sdat_stb |=> sdat_stb [*7] ##1 !sdat_stb;
  endproperty
  a_plen: assert property (p_plen) else $error("Param length");
  property p_slen; dyn ##1 sdat_stb |=> sdat_stb ##1 !sdat_stb; endproperty
  a_slen: assert property (p_slen) else $error("Status length");
  property p_par; dyn |-> hdr_ident[6] == ^{hdr_ident[4], hdr_ident[2:0]}
    && hdr_ident[7] == ~^{hdr_ident[4:3], hdr_ident[1]}; endproperty
  a_par: assert property (p_par) else $error("Bad parity");
  property p_long; hdr_stb && hdr_ident == 8'h3c |=> mdat_stb
    && mdat == 8'h80 ##1 (mdat_stb && mdat[7]) [*2]
    ##1 (mdat_stb && mdat == 8'hff) [*5]; endproperty
  a_long: assert property (p_long) else $error("Long frame");
  property p_cmd; dyn ##1 mdat_stb |-> mdat[7]; endproperty
  a_cmd: assert property (p_cmd) else $error("Command bit");
  property p_wlen; dyn ##1 mdat_stb |=> mdat_stb ##1 frm_end && !mdat_stb;
  endproperty
  a_wlen: assert property (p_wlen) else $error("Short length");
  property p_rd; rdh |=> !mdat_stb [*8]; endproperty
  a_rd: assert property (p_rd) else $error("Data in read");
endmodule // lin_frame_sva

// ===== sim/lin_stepper_cmd_decoder_tb.sv
// Purpose: Bench for master and device joined by the carrier
// Assumes: Register port answers one cycle after a read strobe
// Notes: Random ids, address and memory from a fixed seed
module lin_stepper_cmd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] fm = 7'h66, bc = 7'h5b, ex = 7'h35;
  logic clk_in = 1'h0, rst_n_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
  logic ext_switch_in = 1'h0, motor_moving_in = 1'h0, otp_we_in = 1'h0;
  logic comm_lost_in = 1'h0, init_done_in = 1'h0, irq_out, busy_out;
  logic goto_safe_out, estop_out, bridge_off_out, param_armed_out;
  logic [7:0] reg_addr_in = 8'h00, otp_wdata_in = 8'h00, mem [8];
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic [6:0] node_addr_in = 7'h00;
  logic [4:0] prep_id_in = 5'h00, status_id_in = 5'h00, write_id_in = 5'h00;
  logic [2:0] addr_pins_in = 3'h0, otp_addr_in = 3'h0;
  logic [1:0] temp_level_in = 2'h0, coil_fault_in = 2'h0;
  logic [10:0] safe_pos_in = 11'h000;
  logic [8:0] fault_evt_in = 9'h000, flags_out;
  int fail_count = 0, comparisons = 0, gs = 0, es = 0;
  lin_frame_if link ();
  lin_master_ctrl lin_master_ctrl_inst (.clk_in, .rst_n_in, .bus(link),
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .irq_out, .busy_out);
  lin_stepper_cmd_decoder lin_stepper_cmd_decoder_inst (.clk_in, .rst_n_in,
    .bus(link), .node_addr_in, .prep_id_in, .status_id_in, .write_id_in,
    .addr_pins_in, .ext_switch_in, .temp_level_in, .safe_pos_in,
    .fault_evt_in, .coil_fault_in, .motor_moving_in, .comm_lost_in,
    .init_done_in, .otp_we_in, .otp_addr_in, .otp_wdata_in, .goto_safe_out,
    .estop_out, .bridge_off_out, .flags_out, .param_armed_out);
  lin_frame_sva lin_frame_sva_inst (.clk_in, .rst_n_in,
    .hdr_stb(link.hdr_stb), .hdr_ident(link.hdr_ident),
    .mdat_stb(link.mdat_stb), .mdat(link.mdat), .frm_end(link.frm_end),
    .sdat_stb(link.sdat_stb));
  always #25 clk_in = !clk_in;
  // Pulses counted so no check hinges on one sampled cycle
  always @(posedge clk_in) begin
    gs <= gs + int'(goto_safe_out === 1'h1);
    es <= es + int'(estop_out === 1'h1);
  end
  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= w;
    reg_rd_in <= !w;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
    reg_rd_in <= 1'h0;
    #1 q = reg_rdata_out;
  endtask
  task automatic run(input logic [2:0] op, input logic lf, b,
                     input logic [6:0] a);
    logic [31:0] q;
    int n;
    bus(1'h1, 8'h00, {20'h0_0000, b, a, lf, op}, q);
    n = 0;
    while (busy_out !== 1'h0 && n < 400) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n >= 400) begin
      fail_count++;
      $display("ERROR %0t: command never finished", $time);
      tally_and_finish();
    end
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  function automatic logic [15:0] exp_stat(input logic [8:0] f);
    return {f[8], f[4:0], temp_level_in, ext_switch_in, node_addr_in};
  endfunction
  function automatic logic [63:0] exp_param();
    return {mem[7], mem[6], mem[5], mem[4], mem[3], mem[2], mem[1], mem[0]};
  endfunction
  initial begin
    logic [31:0] q, lo;
    logic [8:0] ev;
    int r, g0, e0, d;
    r = $urandom(32'h6694);
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'h1;
    r = $urandom % 29;
    node_addr_in <= 7'($urandom);
    status_id_in <= 5'(r);
    prep_id_in <= 5'(r + 1);
    write_id_in <= 5'(r + 2);
    {addr_pins_in, ext_switch_in, temp_level_in} <= 6'($urandom);
    safe_pos_in <= 11'($urandom % 1024);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      mem[i] = 8'($urandom);
      otp_we_in <= 1'h1;
      otp_addr_in <= 3'(i);
      otp_wdata_in <= mem[i];
    end
    @(posedge clk_in);
    otp_we_in <= 1'h0;
    chk(64'(flags_out), 64'h100);
    bus(1'h1, 8'h04, {17'h0, write_id_in, status_id_in, prep_id_in}, q);
    bus(1'h1, 8'h10, 32'h1, q);
    @(posedge clk_in);
    ev = 9'($urandom);
    fault_evt_in <= ev;
    @(posedge clk_in);
    fault_evt_in <= 9'h000;
    run(3'h2, 1'h0, 1'h1, node_addr_in);
    bus(1'h0, 8'h14, 32'h0, q);
    chk(64'(q[15:0]), 64'(exp_stat(ev | 9'h100)));
    chk(64'(flags_out), 64'h0);
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_in);
      addr_pins_in <= 3'(f + 5);
      mem[2][6:4] = 3'(f + 5);
      run(3'h1, 1'(f), 1'h1, node_addr_in);
      bus(1'h0, 8'h14, 32'h0, lo);
      bus(1'h0, 8'h18, 32'h0, q);
      chk({q, lo}, exp_param());
      chk(64'(irq_out), 64'h1);
      bus(1'h0, 8'h0c, 32'h0, q);
      @(posedge clk_in);
      #1 chk(64'({q[0], irq_out}), 64'h2);
    end
    // Foreign address never arms, so the read header times out
    run(3'h1, 1'h0, 1'h1, node_addr_in ^ 7'h01);
    bus(1'h0, 8'h0c, 32'h0, q);
    chk(64'({q[1], param_armed_out}), 64'h2);
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_in);
      safe_pos_in <= (k == 3) ? 11'h400 : 11'(safe_pos_in[9:0]);
      g0 = gs;
      e0 = es;
      run(k < 4 ? 3'h3 : 3'h4, 1'h0, bc[k], node_addr_in ^ 7'(fm[k]));
      d = k < 4 ? gs - g0 : es - e0;
      chk(64'(d), 64'(ex[k]));
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_in);
      g0 = gs;
      comm_lost_in <= (j == 0);
      init_done_in <= (j == 1);
      @(posedge clk_in);
      comm_lost_in <= 1'h0;
      init_done_in <= 1'h0;
      repeat (2) @(posedge clk_in);
      #1 chk(64'(gs - g0), 64'h1);
    end
    @(posedge clk_in);
    e0 = es;
    motor_moving_in <= 1'h1;
    coil_fault_in <= 2'h2;
    @(posedge clk_in);
    coil_fault_in <= 2'h0;
    repeat (2) @(posedge clk_in);
    #1 chk({62'h0, bridge_off_out, 1'(es - e0)}, 64'h3);
    chk(64'(flags_out), 64'h18);
    run(3'h2, 1'h0, 1'h1, node_addr_in);
    bus(1'h0, 8'h14, 32'h0, q);
    chk(64'(q[15:0]), 64'(exp_stat(9'h018)));
    chk(64'(bridge_off_out), 64'h0);
    bus(1'h0, 8'hfc, 32'h0, q);
    chk(64'(q), 64'h0);
    tally_and_finish();
  end
endmodule // lin_stepper_cmd_decoder_tb
